// ==== rtl/toc_pkg.sv ====
// constants and state type for the 8-bit timer output compare channel
package toc_pkg;

	// ========================================
	// register offsets (byte addresses)
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_COUNTER = 5'h04;
	localparam logic [4:0] OFS_COMPARE = 5'h08;
	localparam logic [4:0] OFS_IRQ_EN  = 5'h0C;
	localparam logic [4:0] OFS_FLAGS   = 5'h10;
	localparam logic [4:0] OFS_FORCE   = 5'h14;
	localparam logic [4:0] OFS_PORT    = 5'h18;
	localparam logic [4:0] OFS_STATUS  = 5'h1C;

	// ========================================
	// field positions
	localparam int CTRL_WGM_LSB = 0;
	localparam int CTRL_COM_LSB = 2;
	localparam int CTRL_CS_LSB  = 4;
	localparam int BIT_CMP      = 0;
	localparam int BIT_OVF      = 1;
	localparam int BIT_FORCE    = 0;
	localparam int BIT_PORTDAT  = 0;
	localparam int BIT_PINDIR   = 1;
	localparam int BIT_OCSTATE  = 0;
	localparam int BIT_DOWN     = 1;

	// ========================================
	// waveform modes and counter limits
	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_PCPWM  = 2'h1;
	localparam logic [1:0] WGM_CTC    = 2'h2;
	localparam logic [1:0] WGM_FAST   = 2'h3;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam int PSC_W = 10;

	// ========================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_2B   = 2'h0;
	localparam logic [2:0] RST_CS   = 3'h0;

	// ========================================
	// whole block state
	typedef struct packed {
		logic [7:0]       cnt;
		logic [7:0]       ocr;
		logic [7:0]       ocr_buf;
		logic             down;
		logic             cmp_flag;
		logic             ovf_flag;
		logic             match_pend;
		logic             block;
		logic             oc;
		logic [1:0]       wgm;
		logic [1:0]       com;
		logic [2:0]       cs;
		logic             cie;
		logic             oie;
		logic             port_dat;
		logic             pin_dir;
		logic [PSC_W-1:0] psc;
		logic             ack;
		logic [31:0]      rdata;
	} toc_state_s;

endpackage : toc_pkg

// ==== rtl/toc_top.sv ====
// output compare channel of an 8-bit timer with its counter and avalon-mm registers
//
// Function
// - compare counter with compare value each timer clock, flag equality as match
// - compare flag sets one timer clock after the match
// - interrupt request when compare irq enabled and compare flag set
// - compare flag clears when its interrupt is executed
// - writing one clears compare flag, writing zero leaves it
// - pwm modes buffer compare writes, load at top or bottom
// - normal and clear-on-match modes write compare value directly
// - while buffering, software reads and writes reach the buffer
// - force strobe in non-pwm modes acts on output like a match
// - forced match sets no flag and leaves the counter alone
// - counter write blocks any match in the next timer clock
// - compare output keeps its value across waveform mode changes
// - output mode unbuffered, pin override changes at once
// - new output mode acts from next match or force
// - nonzero output mode drives pin from compare output
// - pin direction bit alone decides whether the pin is driven
// - pin override ignores waveform mode
// - output mode zero leaves compare output unchanged on matches
// - count sequence follows waveform mode only
// - pwm: inverting choice, fast pwm output mode 1 toggles; non-pwm: set, clear or toggle
// - normal mode counts up, wraps 0xFF to 0x00
// - normal mode sets overflow flag as counter becomes zero
// - overflow flag clears on interrupt; counter writable anytime
// - waveform codes: 0 normal, 1 phase pwm, 2 clear-on-match, 3 fast pwm
// - counter write beats clear or count in same cycle
// - clock select zero stops the timer clock, counter still accessible
// - non-pwm output mode 1 toggles on match
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps

module toc_top
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        compare_irq_ack,
	input  wire logic        overflow_irq_ack,
	output logic             compare_irq,
	output logic             overflow_irq,
	output logic             compare_output,
	output logic             pin_out,
	output logic             pin_oe
);
	import toc_pkg::*;

	toc_state_s st_ff;
	toc_state_s nxt_st;

	// ========================================
	// prescaler tick selection
	function automatic logic presc_tick(input logic [2:0] sel, input logic [PSC_W-1:0] p);
		logic t;
		t = 1'b0;
		unique case (sel)
			3'h0: t = 1'b0;
			3'h1: t = 1'b1;
			3'h2: t = &p[2:0];
			3'h3: t = &p[4:0];
			3'h4: t = &p[5:0];
			3'h5: t = &p[6:0];
			3'h6: t = &p[7:0];
			3'h7: t = &p[9:0];
		endcase
		return t;
	endfunction : presc_tick

	logic       bus_req;
	logic       wr_now;
	logic       wr_lo;
	logic       tick;
	logic       pwm;
	logic       eq;
	logic       match;
	logic       force_hit;
	logic [7:0] cnt_step;
	logic       wrap_zero;
	logic       at_top;
	logic       set_cmp;
	logic       set_ovf;
	logic [7:0] rd_mux;

	// ========================================
	// bus handshake: one wait state per access
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~st_ff.ack;
	assign wr_now          = avs_write & st_ff.ack;
	assign wr_lo           = wr_now & avs_byteenable[0];
	assign avs_readdata    = st_ff.rdata;

	// ========================================
	// timer clock and compare
	always_comb
	begin
		tick = presc_tick(st_ff.cs, st_ff.psc);
		pwm  = (st_ff.wgm == WGM_PCPWM) || (st_ff.wgm == WGM_FAST);
		eq = (st_ff.cnt == st_ff.ocr);
		match = tick & eq & ~st_ff.block;
		force_hit = wr_lo & avs_address == OFS_FORCE & avs_writedata[BIT_FORCE] & ~pwm;
	end

	// ========================================
	// next counter value per waveform mode
	always_comb
	begin
		cnt_step  = st_ff.cnt;
		wrap_zero = 1'b0;
		at_top    = 1'b0;
		unique case (st_ff.wgm)
			WGM_NORMAL:
			begin
				cnt_step  = st_ff.cnt + 8'h01;
				wrap_zero = (st_ff.cnt == CNT_MAX);
			end
			WGM_CTC:
			begin
				if (eq)
					cnt_step = CNT_BOTTOM;
				else
					cnt_step = st_ff.cnt + 8'h01;
				wrap_zero = (st_ff.cnt == CNT_MAX) & ~eq;
			end
			WGM_FAST:
			begin
				cnt_step  = st_ff.cnt + 8'h01;
				wrap_zero = (st_ff.cnt == CNT_MAX);
				at_top    = (cnt_step == CNT_MAX);
			end
			WGM_PCPWM:
			begin
				if (st_ff.down)
					cnt_step = st_ff.cnt - 8'h01;
				else
					cnt_step = st_ff.cnt + 8'h01;
				at_top = (cnt_step == CNT_MAX) & ~st_ff.down;
			end
		endcase
	end

	// ========================================
	// flag set events
	always_comb
	begin
		// flag set on tick after match
		set_cmp = tick & st_ff.match_pend;
		unique case (st_ff.wgm)
			WGM_NORMAL: set_ovf = tick & wrap_zero;
			WGM_CTC:    set_ovf = tick & wrap_zero;
			WGM_FAST:   set_ovf = tick & at_top;
			WGM_PCPWM:  set_ovf = tick & st_ff.down & (cnt_step == CNT_BOTTOM);
		endcase
	end

	// ========================================
	// register read mux
	always_comb
	begin
		rd_mux = RST_BYTE;
		unique case (avs_address)
			OFS_CTRL:    rd_mux = {1'b0, st_ff.cs, st_ff.com, st_ff.wgm};
			OFS_COUNTER: rd_mux = st_ff.cnt;
			OFS_COMPARE: rd_mux = pwm ? st_ff.ocr_buf : st_ff.ocr;
			OFS_IRQ_EN:  rd_mux = {6'h00, st_ff.oie, st_ff.cie};
			OFS_FLAGS:   rd_mux = {6'h00, st_ff.ovf_flag, st_ff.cmp_flag};
			OFS_PORT:    rd_mux = {6'h00, st_ff.pin_dir, st_ff.port_dat};
			OFS_STATUS:  rd_mux = {6'h00, st_ff.down, st_ff.oc};
			default:     rd_mux = RST_BYTE;
		endcase
	end

	// ========================================
	// next state
	always_comb
	begin
		nxt_st     = st_ff;
		nxt_st.ack = bus_req & ~st_ff.ack;
		if (bus_req & ~st_ff.ack)
			nxt_st.rdata = {24'h000000, rd_mux};
		nxt_st.psc = st_ff.psc + 10'h001;

		// counter, direction and match pipeline
		if (tick)
		begin
			nxt_st.cnt        = cnt_step;
			nxt_st.match_pend = match;
			nxt_st.block      = 1'b0;
			if (st_ff.wgm == WGM_PCPWM)
			begin
				if (at_top)
					nxt_st.down = 1'b1;
				else if (st_ff.down & (cnt_step == CNT_BOTTOM))
					nxt_st.down = 1'b0;
			end
			else
				nxt_st.down = 1'b0;
			// fast pwm loads at bottom, phase pwm at top
			if ((st_ff.wgm == WGM_FAST & wrap_zero) | (st_ff.wgm == WGM_PCPWM & at_top))
				nxt_st.ocr = st_ff.ocr_buf;
		end

		// compare output waveform; mode changes leave oc alone
		// state kept across modes
		if (match | force_hit)
		begin
			unique case (st_ff.com)
				2'h0: nxt_st.oc = st_ff.oc;
				2'h1: nxt_st.oc = (st_ff.wgm == WGM_PCPWM) ? st_ff.oc : ~st_ff.oc;
				// clear for 2, set for 3 outside phase pwm; phase pwm follows count direction
				2'h2: nxt_st.oc = (st_ff.wgm == WGM_PCPWM) ? st_ff.down : 1'b0;
				2'h3: nxt_st.oc = (st_ff.wgm == WGM_PCPWM) ? ~st_ff.down : 1'b1;
			endcase
		end
		if (tick & st_ff.wgm == WGM_FAST & wrap_zero & st_ff.com[1])
			nxt_st.oc = ~st_ff.com[0];

		// software writes
		if (wr_lo)
		begin
			unique case (avs_address)
				OFS_CTRL:
				begin
					nxt_st.wgm = avs_writedata[CTRL_WGM_LSB +: 2];
					nxt_st.com = avs_writedata[CTRL_COM_LSB +: 2];
					nxt_st.cs  = avs_writedata[CTRL_CS_LSB +: 3];
				end
				OFS_COUNTER:
				begin
					nxt_st.cnt   = avs_writedata[7:0];
					nxt_st.block = 1'b1;
				end
				OFS_COMPARE:
				begin
					nxt_st.ocr_buf = avs_writedata[7:0];
					if (!pwm)
						nxt_st.ocr = avs_writedata[7:0];
				end
				OFS_IRQ_EN:
				begin
					nxt_st.cie = avs_writedata[BIT_CMP];
					nxt_st.oie = avs_writedata[BIT_OVF];
				end
				OFS_PORT:
				begin
					nxt_st.port_dat = avs_writedata[BIT_PORTDAT];
					nxt_st.pin_dir  = avs_writedata[BIT_PINDIR];
				end
				default:
				begin
				end
			endcase
		end

		// flags: set wins over any clear
		// write one clears
		if (wr_lo & avs_address == OFS_FLAGS & avs_writedata[BIT_CMP])
			nxt_st.cmp_flag = 1'b0;
		if (compare_irq_ack)
			nxt_st.cmp_flag = 1'b0;
		if (set_cmp)
			nxt_st.cmp_flag = 1'b1;
		if (wr_lo & avs_address == OFS_FLAGS & avs_writedata[BIT_OVF])
			nxt_st.ovf_flag = 1'b0;
		if (overflow_irq_ack)
			nxt_st.ovf_flag = 1'b0;
		if (set_ovf)
			nxt_st.ovf_flag = 1'b1;
	end

	// ========================================
	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// ========================================
	// outputs
	// interrupt requests
	assign compare_irq    = st_ff.cmp_flag & st_ff.cie;
	assign overflow_irq   = st_ff.ovf_flag & st_ff.oie;
	assign compare_output = st_ff.oc;
	assign pin_out = (st_ff.com != RST_2B) ? st_ff.oc : st_ff.port_dat;
	assign pin_oe  = st_ff.pin_dir;

endmodule : toc_top

// ==== sim/testbench.sv ====
// self-checking testbench for the timer output compare channel
`timescale 1ns/1ps

module testbench;
	import toc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  adr;
	logic        rd, wr_s, c_ack, o_ack;
	logic [31:0] wdat, rdat;
	logic [3:0]  ben;
	logic        wait_s, compare_irq, overflow_irq, compare_output, pin_out, pin_oe;
	int          n_errors = 0;
	int          total_checks = 0;
	logic [1:0]  cm[5] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h0};
	logic [7:0]  ex[5] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h01};

	always #50 clk = ~clk;

	toc_cpu cpu (.clk(clk), .avs_readdata(rdat), .avs_waitrequest(wait_s), .avs_address(adr), .avs_read(rd),
		.avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(ben), .c_ack(c_ack), .o_ack(o_ack));
	toc_top dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr_s),
		.avs_writedata(wdat), .avs_byteenable(ben), .avs_readdata(rdat), .avs_waitrequest(wait_s),
		.compare_irq_ack(c_ack), .overflow_irq_ack(o_ack), .compare_irq(compare_irq),
		.overflow_irq(overflow_irq), .compare_output(compare_output), .pin_out(pin_out), .pin_oe(pin_oe));

	// ========================================
	// helpers
	function automatic logic [7:0] ctl(input logic [1:0] w, input logic [1:0] c, input logic [2:0] s);
		return {1'b0, s, c, w};
	endfunction : ctl
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] q;
		cpu.xfer(a, 1'b0, 8'h00, q);
		chk(q, exp);
	endtask : rchk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		cpu.xfer(a, 1'b1, d, q);
		@(negedge clk);
	endtask : wr
	task automatic await(input logic ovf, input int lim);
		int i;
		i = 0;
		while (((ovf ? overflow_irq : compare_irq) !== 1'b1) && i < lim)
		begin
			@(posedge clk);
			i++;
		end
		chk({7'h00, (ovf ? overflow_irq : compare_irq)}, 8'h01);
	endtask : await
	task automatic conclude;
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	// ========================================
	// watchdog
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		conclude();
	end

	// ========================================
	// test sequence
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk(OFS_CTRL, 8'h00);
		rchk(OFS_FLAGS, 8'h00);
		wr(OFS_COMPARE, 8'h10);
		rchk(OFS_COMPARE, 8'h10);
		wr(5'h02, 8'h55);
		rchk(5'h02, 8'h00);
		$display("test registers done");
		wr(OFS_PORT, 8'h03);
		chk({7'h00, pin_oe}, 8'h01);
		for (int k = 0; k < 5; k++)
		begin
			wr(OFS_CTRL, ctl(WGM_NORMAL, cm[k], 3'h0));
			wr(OFS_FORCE, 8'h01);
			chk({7'h00, compare_output}, ex[k]);
			chk({7'h00, pin_out}, (cm[k] != 2'h0) ? ex[k] : 8'h01);
		end
		rchk(OFS_FLAGS, 8'h00);
		rchk(OFS_COUNTER, 8'h00);
		wr(OFS_CTRL, ctl(WGM_FAST, 2'h1, 3'h0));
		wr(OFS_FORCE, 8'h01);
		chk({7'h00, compare_output}, 8'h01);
		$display("test force done");
		wr(OFS_COMPARE, 8'h40);
		rchk(OFS_COMPARE, 8'h40);
		wr(OFS_COUNTER, 8'h05);
		wr(OFS_IRQ_EN, 8'h03);
		wr(OFS_CTRL, ctl(WGM_FAST, 2'h0, 3'h1));
		await(1'b0, 30);
		wr(OFS_CTRL, ctl(WGM_NORMAL, 2'h1, 3'h0));
		wr(OFS_COMPARE, 8'h10);
		wr(OFS_COUNTER, 8'h10);
		wr(OFS_FLAGS, 8'h03);
		wr(OFS_CTRL, ctl(WGM_NORMAL, 2'h1, 3'h1));
		// wait long enough for a match at the written count to reach the flag had it not been blocked, then check the flag stays clear
		repeat (2) @(posedge clk);
		rchk(OFS_FLAGS, 8'h00);
		$display("test buffer and block done");
		await(1'b0, 300);
		chk({7'h00, compare_output}, 8'h00);
		cpu.pulse(1'b0);
		@(negedge clk);
		chk({7'h00, compare_irq}, 8'h00);
		await(1'b0, 300);
		wr(OFS_CTRL, ctl(WGM_NORMAL, 2'h1, 3'h0));
		wr(OFS_FLAGS, 8'h00);
		rchk(OFS_FLAGS, 8'h03);
		wr(OFS_FLAGS, 8'h01);
		rchk(OFS_FLAGS, 8'h02);
		cpu.pulse(1'b1);
		@(negedge clk);
		chk({7'h00, overflow_irq}, 8'h00);
		wr(OFS_COUNTER, 8'hFE);
		wr(OFS_CTRL, ctl(WGM_NORMAL, 2'h0, 3'h1));
		await(1'b1, 10);
		$display("test match and flags done");
		// clear-on-match: small top, so no overflow, set action on match
		wr(OFS_CTRL, ctl(WGM_CTC, 2'h2, 3'h0));
		wr(OFS_FORCE, 8'h01);
		wr(OFS_COUNTER, 8'h00);
		wr(OFS_COMPARE, 8'h03);
		wr(OFS_FLAGS, 8'h03);
		wr(OFS_CTRL, ctl(WGM_CTC, 2'h3, 3'h1));
		repeat (300) @(posedge clk);
		wr(OFS_CTRL, ctl(WGM_CTC, 2'h2, 3'h0));
		rchk(OFS_FLAGS, 8'h01);
		chk({7'h00, compare_output}, 8'h01);
		// phase pwm non-inverted: clear on up match, set on down match
		wr(OFS_FORCE, 8'h01);
		chk({7'h00, compare_output}, 8'h00);
		wr(OFS_COUNTER, 8'h00);
		wr(OFS_FLAGS, 8'h03);
		wr(OFS_CTRL, ctl(WGM_PCPWM, 2'h2, 3'h1));
		await(1'b1, 600);
		chk({7'h00, compare_output}, 8'h01);
		$display("test ctc and phase pwm done");
		conclude();
	end
endmodule : testbench

// ==== sim/toc_cpu.sv ====
// cpu model: avalon-mm master and interrupt acknowledge pulses
`timescale 1ns/1ps

module toc_cpu
(
	input  wire logic        clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	output logic             c_ack,
	output logic             o_ack
);
	// ========================================
	// idle bus at time zero
	initial
	begin
		{avs_address, avs_read, avs_write, avs_writedata, c_ack, o_ack} = '0;
		avs_byteenable = 4'h1;
	end

	// ========================================
	// one bus access, held until waitrequest is sampled low
	task automatic xfer(input logic [4:0] a, input logic rw, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !rw;
		avs_write <= rw;
		avs_writedata <= {24'h000000, d};
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer

	// ========================================
	// one-cycle interrupt executed pulse
	task automatic pulse(input logic ovf);
		@(posedge clk);
		if (ovf)
			o_ack <= 1'b1;
		else
			c_ack <= 1'b1;
		@(posedge clk);
		c_ack <= 1'b0;
		o_ack <= 1'b0;
	endtask : pulse
endmodule : toc_cpu

// ==== sim/toc_top_props.sv ====
// checker for the timer output compare channel ports
`timescale 1ns/1ps

module toc_top_props
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        compare_irq_ack,
	input wire logic        overflow_irq_ack,
	input wire logic        compare_irq,
	input wire logic        overflow_irq,
	input wire logic        compare_output,
	input wire logic        pin_out,
	input wire logic        pin_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ========================================
	// properties
	property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
	property p_wait_bound; avs_waitrequest |=> !avs_waitrequest; endproperty
	property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
	property p_rdhi; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000; endproperty
	property p_pin; $changed(pin_out) |-> $changed(compare_output) || $past(avs_write && !avs_waitrequest); endproperty
	property p_oe; $changed(pin_oe) |-> $past(avs_write && !avs_waitrequest); endproperty
	property p_cfall; $fell(compare_irq) |-> $past(compare_irq_ack || (avs_write && !avs_waitrequest)); endproperty
	property p_ofall; $fell(overflow_irq) |-> $past(overflow_irq_ack || (avs_write && !avs_waitrequest)); endproperty
	// ========================================
	// assertions
	a_wait: assert property (p_wait) else $error("wait state count wrong");
	a_wait_bound: assert property (p_wait_bound) else $error("waitrequest held too long");
	a_idle: assert property (p_idle) else $error("waitrequest while idle");
	a_rdhi: assert property (p_rdhi) else $error("read data upper bits set");
	a_pin: assert property (p_pin) else $error("pin moved without cause");
	a_oe: assert property (p_oe) else $error("pin enable moved without write");
	a_cfall: assert property (p_cfall) else $error("compare irq dropped without cause");
	a_ofall: assert property (p_ofall) else $error("overflow irq dropped without cause");
	c_cirq: cover property ($rose(compare_irq));
	c_oirq: cover property ($rose(overflow_irq));
	c_oc: cover property ($changed(compare_output));
endmodule : toc_top_props

bind toc_top toc_top_props u_props (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .compare_irq_ack(compare_irq_ack),
	.overflow_irq_ack(overflow_irq_ack), .compare_irq(compare_irq), .overflow_irq(overflow_irq),
	.compare_output(compare_output), .pin_out(pin_out), .pin_oe(pin_oe));
